// ### hdl/dppm_top.sv
// dppm_top: mode-strap multiplexing of the diagnostic pins and the I/O ring.
// assumes: pins and strap are asynchronous to CLK_I; NODE_I is on CLK_I;
// the diagnostic clock is far slower than CLK_I (bench: 160 ns period).
`include "dppm_params.svh"

module dppm_top (
    input  wire logic                        CLK_I,           // system clock, 100 MHz
    input  wire logic                        RST_I,           // async reset, high
    input  wire logic                        MODE_STRAP_I,    // diagnostic mode strap pin
    input  wire logic                        LOCK_STATE_I,    // stored probe-lock state
    input  wire logic                        GCLK_AS_IO_I,    // global clock pin is user I/O
    input  wire dppm_pkg::dppm_io_mode_t     IO_MODE_I [`DPPM_NUM_PINS], // per-pin buffer use
    input  wire logic [`DPPM_NUM_PINS-1:0]   USER_OUT_I,      // user output levels
    input  wire logic [`DPPM_NUM_PINS-1:0]   USER_OE_I,       // user output enables
    input  wire logic [`DPPM_NODE_W-1:0]     NODE_I,          // internal design nodes
    input  wire logic [`DPPM_NUM_PINS-1:0]   PAD_IN_I,        // pin levels
    output logic      [`DPPM_NUM_PINS-1:0]   PAD_OUT_O,       // pin drive levels
    output logic      [`DPPM_NUM_PINS-1:0]   PAD_OE_O,        // pin drive enables
    output logic      [`DPPM_NUM_PINS-1:0]   USER_IN_O,       // synchronised pin levels
    output logic                             GLOBAL_CLK_O,    // buffered global clock
    output logic                             DIAG_ACTIVE_O,   // diagnostic mode in force
    output logic                             PROBE_LOCKED_O,  // probe capability disabled
    output logic                             LOCK_BURN_O      // pulse: burn the lock fuse
);
    import dppm_pkg::*;

    // ****************************************
    // strap and lock synchronisers
    // ****************************************
    logic mode_m;
    logic mode_q;
    logic lock_m;
    logic lock_q;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_m <= 1'b0;
            mode_q <= 1'b0;
            lock_m <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            mode_m <= MODE_STRAP_I;
            mode_q <= mode_m;
            lock_m <= LOCK_STATE_I;
            lock_q <= lock_m;
        end
    end

    // ****************************************
    // diagnostic clock edge and serial frame
    // ****************************************
    logic                         diag_clock_d;
    logic                         blown;
    logic                         burn;
    logic                         sel_load;
    dppm_cnt_t                    bit_cnt;
    logic [`DPPM_FRAME_BITS-1:0]  shift;
    dppm_sel_t                    sel_a;
    dppm_sel_t                    sel_b;
    logic [`DPPM_NUM_PINS-1:0]    pin_in_s;

    wire diag_clock_s  = pin_in_s[`DPPM_PIN_DIAG_CLOCK];
    wire diag_serial_s = pin_in_s[`DPPM_PIN_DIAG_SERIAL];
    // diag clock edge used only in diagnostic mode
    wire diag_clock_rise = mode_q && diag_clock_s && !diag_clock_d;
    wire frame_end = diag_clock_rise && (bit_cnt == `DPPM_CNT_LAST);
    // serial bit taken at the rising edge
    wire [`DPPM_FRAME_BITS-1:0] next_shift = {shift[`DPPM_FRAME_BITS-2:0], diag_serial_s};
    wire [1:0]  frame_op   = next_shift[`DPPM_FRAME_BITS-1:`DPPM_FRAME_BITS-2];
    wire        op_select  = frame_end && (frame_op == `DPPM_OP_SELECT);
    wire        op_lock    = frame_end && (frame_op == `DPPM_OP_LOCK) && !blown;
    wire dppm_cnt_t next_cnt = frame_end ? '0 : dppm_cnt_t'(bit_cnt + 1'b1);
    wire        locked     = blown || lock_q;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            diag_clock_d <= 1'b0;
            bit_cnt <= '0;
            shift   <= '0;
        end else begin
            diag_clock_d <= diag_clock_s;
            if (!mode_q) begin
                bit_cnt <= '0;
            end else if (diag_clock_rise) begin
                bit_cnt <= next_cnt;
                shift   <= next_shift;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sel_a    <= `DPPM_SEL_RST;
            sel_b    <= `DPPM_SEL_RST;
            sel_load <= 1'b0;
        end else begin
            sel_load <= op_select;
            if (op_select) begin
                sel_a <= next_shift[`DPPM_SEL_W-1:0];
                sel_b <= next_shift[2*`DPPM_SEL_W-1:`DPPM_SEL_W];
            end
        end
    end

    // lock is sticky until RST_I clears it; the fuse keeps it after that
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            blown <= 1'b0;
            burn  <= 1'b0;
        end else begin
            burn <= op_lock;
            if (op_lock) begin
                blown <= 1'b1;
            end
        end
    end

    // ****************************************
    // special-function pin overrides
    // ****************************************
    logic [`DPPM_NUM_PINS-1:0] spec_en;
    logic [`DPPM_NUM_PINS-1:0] spec_out;
    logic [`DPPM_NUM_PINS-1:0] spec_oe;

    wire node_a = NODE_I[sel_a];
    wire node_b = NODE_I[sel_b];

    // clock pin held as input when buffering the clock
    assign spec_en[`DPPM_PIN_GCLK]  = !GCLK_AS_IO_I;
    assign spec_out[`DPPM_PIN_GCLK] = 1'b0;
    assign spec_oe[`DPPM_PIN_GCLK]  = 1'b0;
    // diag clock pin is an input in diagnostic mode
    assign spec_en[`DPPM_PIN_DIAG_CLOCK]   = mode_q;
    assign spec_out[`DPPM_PIN_DIAG_CLOCK]  = 1'b0;
    assign spec_oe[`DPPM_PIN_DIAG_CLOCK]   = 1'b0;
    // serial pin is an input in diagnostic mode
    assign spec_en[`DPPM_PIN_DIAG_SERIAL]  = mode_q;
    assign spec_out[`DPPM_PIN_DIAG_SERIAL] = 1'b0;
    assign spec_oe[`DPPM_PIN_DIAG_SERIAL]  = 1'b0;
    // probe A drive, held low once locked
    assign spec_en[`DPPM_PIN_PROBE_OUT_A]  = mode_q;
    assign spec_out[`DPPM_PIN_PROBE_OUT_A] = node_a && !locked;
    assign spec_oe[`DPPM_PIN_PROBE_OUT_A]  = 1'b1;
    // probe B drive, held low once locked
    assign spec_en[`DPPM_PIN_PROBE_OUT_B]  = mode_q;
    assign spec_out[`DPPM_PIN_PROBE_OUT_B] = node_b && !locked;
    assign spec_oe[`DPPM_PIN_PROBE_OUT_B]  = 1'b1;

    // ****************************************
    // I/O ring
    // ****************************************
    genvar k;
    generate
        for (k = 0; k < `DPPM_NUM_PINS; k = k + 1) begin : g_pin
            dppm_io_cell u_cell (
                .clk_i         (CLK_I),
                .rst_i         (RST_I),
                .mode_i        (IO_MODE_I[k]),
                .user_out_i    (USER_OUT_I[k]),
                .user_oe_i     (USER_OE_I[k]),
                .spec_en_i     (spec_en[k]),
                .spec_out_i    (spec_out[k]),
                .spec_oe_i     (spec_oe[k]),
                .pad_in_i      (PAD_IN_I[k]),
                .pad_out_o     (PAD_OUT_O[k]),
                .pad_oe_o      (PAD_OE_O[k]),
                .pad_in_sync_o (pin_in_s[k])
            );
        end
    endgenerate

    logic gclk_buf;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            gclk_buf <= 1'b0;
        end else begin
            gclk_buf <= pin_in_s[`DPPM_PIN_GCLK] && !GCLK_AS_IO_I;
        end
    end

    assign USER_IN_O      = pin_in_s;
    assign GLOBAL_CLK_O   = gclk_buf;
    assign DIAG_ACTIVE_O  = mode_q;
    assign PROBE_LOCKED_O = locked;
    assign LOCK_BURN_O    = burn;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    a_diag_clock_input: assert property (
        mode_q |=> !PAD_OE_O[`DPPM_PIN_DIAG_CLOCK])
        else $error("diag clock pin driven in diagnostic mode");
    a_diag_serial_input: assert property (
        mode_q |=> !PAD_OE_O[`DPPM_PIN_DIAG_SERIAL])
        else $error("serial pin driven in diagnostic mode");
    a_probe_a_node: assert property (
        (mode_q && !locked) |=> (PAD_OE_O[`DPPM_PIN_PROBE_OUT_A]
            && PAD_OUT_O[`DPPM_PIN_PROBE_OUT_A] == $past(node_a)))
        else $error("probe A does not follow its node");
    a_probe_b_node: assert property (
        (mode_q && !locked) |=> (PAD_OE_O[`DPPM_PIN_PROBE_OUT_B]
            && PAD_OUT_O[`DPPM_PIN_PROBE_OUT_B] == $past(node_b)))
        else $error("probe B does not follow its node");
    a_select_load: assert property (
        op_select |=> (sel_a == $past(next_shift[3:0]) && sel_b == $past(next_shift[7:4])))
        else $error("probe selection not loaded from frame");
    a_probe_locked: assert property (
        (mode_q && locked) |=> (!PAD_OUT_O[`DPPM_PIN_PROBE_OUT_A]
            && !PAD_OUT_O[`DPPM_PIN_PROBE_OUT_B]))
        else $error("locked probe exposes a node");
    a_lock_sticky: assert property (
        blown |=> blown [*2])
        else $error("probe lock cleared");
    a_gclk_buffer: assert property (
        !GCLK_AS_IO_I |=> (GLOBAL_CLK_O == $past(pin_in_s[`DPPM_PIN_GCLK])
            && !PAD_OE_O[`DPPM_PIN_GCLK]))
        else $error("global clock not buffered");
    a_serial_sample: assert property (
        diag_clock_rise |=> (shift[0] == $past(diag_serial_s) && bit_cnt != $past(bit_cnt)))
        else $error("serial bit not sampled at diag clock edge");
    a_user_mode_clock: assert property (
        (!mode_q && IO_MODE_I[`DPPM_PIN_DIAG_CLOCK] == IO_OUTPUT)
            |=> PAD_OE_O[`DPPM_PIN_DIAG_CLOCK])
        else $error("diag clock pin not user I/O in user mode");

    c_enter_diag: cover property ($rose(mode_q));
    c_select_frame: cover property (op_select ##1 sel_load);
    c_lock_burn: cover property (op_lock ##1 LOCK_BURN_O);
endmodule

// ### hdl/dppm_params.svh
// dppm_params.svh: constants of the diagnostic probe pin multiplexer.
// assumes: included by bare name from the package and the design modules.
`ifndef DPPM_PARAMS_SVH
`define DPPM_PARAMS_SVH

// pin indices of the multifunction pin group
`define DPPM_NUM_PINS         5
`define DPPM_PIN_GCLK         0
`define DPPM_PIN_DIAG_CLOCK   1
`define DPPM_PIN_DIAG_SERIAL  2
`define DPPM_PIN_PROBE_OUT_A  3
`define DPPM_PIN_PROBE_OUT_B  4

// internal node bus and probe selection
`define DPPM_NODE_W      16
`define DPPM_SEL_W       4
`define DPPM_SEL_RST     4'h0

// serial frame: op[1:0], select b[3:0], select a[3:0], most significant bit first
`define DPPM_FRAME_BITS  10
`define DPPM_CNT_W       4
`define DPPM_CNT_LAST    4'h9
`define DPPM_OP_SELECT   2'h1
`define DPPM_OP_LOCK     2'h2

`endif

// ### hdl/dppm_pkg.sv
// dppm_pkg: types of the diagnostic probe pin multiplexer.
// assumes: dppm_params.svh on the include path.
`include "dppm_params.svh"

package dppm_pkg;

    // configured use of one user I/O pin
    typedef enum logic [2:0] {
        IO_INPUT,
        IO_OUTPUT,
        IO_TRISTATE,
        IO_BIDIR,
        IO_UNUSED
    } dppm_io_mode_t;

    typedef logic [`DPPM_SEL_W-1:0] dppm_sel_t;
    typedef logic [`DPPM_CNT_W-1:0] dppm_cnt_t;

endpackage

// ### hdl/dppm_io_cell.sv
// dppm_io_cell: one I/O buffer cell with a special-function override.
// assumes: pad_in_i comes from a pin; all other inputs are on clk_i.
`include "dppm_params.svh"

module dppm_io_cell (
    input  wire logic                   clk_i,       // system clock
    input  wire logic                   rst_i,       // async reset, high
    input  wire dppm_pkg::dppm_io_mode_t mode_i,     // configured buffer use
    input  wire logic                   user_out_i,  // user output level
    input  wire logic                   user_oe_i,   // user enable (tristate/bidir)
    input  wire logic                   spec_en_i,   // special function owns the pin
    input  wire logic                   spec_out_i,  // special output level
    input  wire logic                   spec_oe_i,   // special output enable
    input  wire logic                   pad_in_i,    // pin level
    output logic                        pad_out_o,   // pin drive level
    output logic                        pad_oe_o,    // pin drive enable
    output logic                        pad_in_sync_o // synchronised pin level
);
    import dppm_pkg::*;

    // ****************************************
    // buffer mode decode
    // ****************************************
    logic sync_m;
    logic sync_q;

    wire  mode_always = (mode_i == IO_OUTPUT) || (mode_i == IO_UNUSED);
    wire  mode_gated  = (mode_i == IO_TRISTATE) || (mode_i == IO_BIDIR);
    wire  user_oe     = mode_always || (mode_gated && user_oe_i);
    wire  user_level  = (mode_i == IO_UNUSED) ? 1'b0 : user_out_i;
    wire  next_oe     = spec_en_i ? spec_oe_i  : user_oe;
    wire  next_out    = spec_en_i ? spec_out_i : (user_oe & user_level);

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pad_out_o <= 1'b0;
            pad_oe_o  <= 1'b0;
            sync_m    <= 1'b0;
            sync_q    <= 1'b0;
        end else begin
            pad_out_o <= next_out;
            pad_oe_o  <= next_oe;
            sync_m    <= pad_in_i;
            sync_q    <= sync_m;
        end
    end

    assign pad_in_sync_o = sync_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_input_mode_float: assert property (
        (!spec_en_i && mode_i == IO_INPUT) |=> !pad_oe_o)
        else $error("input-mode pin is driven");
    a_unused_pin_low: assert property (
        (!spec_en_i && mode_i == IO_UNUSED) |=> (pad_oe_o && !pad_out_o))
        else $error("unused pin not driven low");
    a_tristate_gate: assert property (
        (!spec_en_i && mode_i == IO_TRISTATE && !user_oe_i) |=> !pad_oe_o)
        else $error("tristate pin driven while disabled");
endmodule

// ### tb/dppm_diag_tool.sv
// dppm_diag_tool: external probe tool driving the diag clock and serial data.
// assumes: the bench routes these to the pins only while the strap is high.
module dppm_diag_tool (
    output logic diag_clock_o,  // diag clock, low between frames
    output logic diag_serial_o  // serial data, most significant bit first
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        diag_clock_o  = 1'b0;
        diag_serial_o = 1'b0;
    end

    // data set at the start of the low phase, held past the rise
    task automatic send_frame(input logic [9:0] frame);
        for (int i = 9; i >= 0; i--) begin
            diag_serial_o = frame[i];
            #80;
            diag_clock_o = 1'b1;
            #80;
            diag_clock_o = 1'b0;
        end
        diag_serial_o = ~frame[0];
    endtask
endmodule

// ### tb/diag_probe_pin_mux_tb.sv
// diag_probe_pin_mux_tb: self-checking bench of the probe pin multiplexer.
// assumes: dppm_pkg compiled first, dppm_params.svh on the include path.
`include "dppm_params.svh"

module diag_probe_pin_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dppm_pkg::*;

    // ****************************************
    // signals and design
    // ****************************************
    logic          clk, rst, strap, lock_state, gclk_io;
    dppm_io_mode_t io_mode [`DPPM_NUM_PINS];
    logic [4:0]    user_out, user_oe, tb_pin, pad_in, pad_out, pad_oe, user_in;
    logic [15:0]   node;
    logic          gclk_o, diag_act, locked, burn, tool_clk, tool_data;
    int            n_fail, n_checks, n_burn;
    wire  [4:0]    ext = {tb_pin[4:3], strap ? tool_data : tb_pin[2],
                          strap ? tool_clk : tb_pin[1], tb_pin[0]};

    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);

    dppm_diag_tool tool (.diag_clock_o(tool_clk), .diag_serial_o(tool_data));

    dppm_top uut (
        .CLK_I(clk), .RST_I(rst), .MODE_STRAP_I(strap), .LOCK_STATE_I(lock_state),
        .GCLK_AS_IO_I(gclk_io), .IO_MODE_I(io_mode), .USER_OUT_I(user_out),
        .USER_OE_I(user_oe), .NODE_I(node), .PAD_IN_I(pad_in), .PAD_OUT_O(pad_out),
        .PAD_OE_O(pad_oe), .USER_IN_O(user_in), .GLOBAL_CLK_O(gclk_o),
        .DIAG_ACTIVE_O(diag_act), .PROBE_LOCKED_O(locked), .LOCK_BURN_O(burn)
    );

    always #5 clk = ~clk;

    always @(posedge clk) begin
        if (burn === 1'b1) n_burn++;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset;
        rst = 1'b1;
        step(8);
        rst = 1'b0;
        step(1);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_user_modes;
        logic [4:0] eo;
        strap = 1'b0;
        gclk_io = 1'b1;
        tb_pin = 5'h15;
        for (int m = 0; m < 5; m++) begin
            for (int i = 0; i < 5; i++) io_mode[i] = dppm_io_mode_t'(m);
            step(5);
            eo = (m == 0) ? 5'h00 : (m == 2 || m == 3) ? user_oe : 5'h1F;
            chk("pad_oe", {11'h000, eo}, {11'h000, pad_oe});
            chk("pad_out", {11'h000, (m == 4) ? 5'h00 : eo & user_out},
                {11'h000, pad_out});
            if (m == 0) chk("user_in", 16'h0015, {11'h000, user_in});
        end
    endtask

    task automatic test_gclk;
        gclk_io = 1'b0;
        tb_pin[0] = 1'b1;
        step(6);
        chk("gclk", 16'h0001, {15'h0000, gclk_o});
        tb_pin[0] = 1'b0;
        step(6);
        chk("gclk", 16'h0000, {15'h0000, gclk_o});
        // clock pin handed back as a plain user input
        io_mode[0] = IO_INPUT;
        gclk_io = 1'b1;
        tb_pin[0] = 1'b1;
        step(6);
        chk("gclk_io", 16'h0001, {14'h0000, gclk_o, user_in[0]});
    endtask

    task automatic frame_probe(input logic [9:0] f, input logic [1:0] exp);
        tool.send_frame(f);
        step(8);
        chk("probes", {14'h0000, exp}, {14'h0000, pad_out[4:3]});
    endtask

    task automatic test_probe_select;
        strap = 1'b1;
        node = 16'h0421;
        step(10);
        chk("diag_act", 16'h0001, {15'h0000, diag_act});
        chk("pad_oe", 16'h0018, {11'h000, pad_oe});
        chk("probes", 16'h0003, {14'h0000, pad_out[4:3]});
        frame_probe({2'h1, 4'h3, 4'h5}, 2'b01);
        frame_probe({2'h1, 4'hA, 4'h4}, 2'b10);
        frame_probe({2'h3, 4'h0, 4'h0}, 2'b10);
        node = ~16'h0421;
        step(3);
        chk("probes", 16'h0001, {14'h0000, pad_out[4:3]});
        chk("burn", 16'h0000, n_burn[15:0]);
    endtask

    task automatic test_lock;
        frame_probe({2'h2, 8'h00}, 2'b00);
        chk("burn", 16'h0001, n_burn[15:0]);
        chk("locked", 16'h0003, {14'h0000, locked, pad_oe[3]});
        tool.send_frame({2'h2, 8'h00});
        step(8);
        chk("burn", 16'h0001, n_burn[15:0]);
        lock_state = 1'b1;
        do_reset;
        step(10);
        chk("locked", 16'h0001, {15'h0000, locked});
        frame_probe({2'h1, 4'h3, 4'h5}, 2'b00);
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        strap = 1'b0;
        lock_state = 1'b0;
        gclk_io = 1'b1;
        for (int i = 0; i < 5; i++) io_mode[i] = IO_INPUT;
        user_out = 5'h1B;
        user_oe = 5'h0A;
        node = 16'h0000;
        tb_pin = 5'h00;
        n_fail = 0;
        n_checks = 0;
        n_burn = 0;
        do_reset;
        test_user_modes;
        test_gclk;
        test_probe_select;
        test_lock;
        give_verdict;
    end

    initial begin
        #200us;
        n_fail++;
        $display("[ERR] run_time expected done seen timeout");
        give_verdict;
    end
endmodule
